// >>> inc/hpcr_pkg.sv
// Constants and types for the hardware pin configuration register bank.
// Assumes a single 25 MHz clock; register offsets are the byte offsets of the configuration map.
package hpcr_pkg;

  // Clock rate, used to turn times into cycle counts.
  localparam int CLK_MHZ = 25;

  // Register offsets of the bank.
  localparam logic [7:0] OFS_PIN_A  = 8'hA4;
  localparam logic [7:0] OFS_PIN_B  = 8'hA6;
  localparam logic [7:0] OFS_DEVICE = 8'hA8;

  // Reset values of the three registers.
  localparam logic [31:0] RST_PIN_A  = 32'h0000_0000;
  localparam logic [31:0] RST_PIN_B  = 32'h0000_0000;
  localparam logic [31:0] RST_DEVICE = 32'h0000_0000;

  // Writable-bit masks; reserved positions are held at zero.
  localparam logic [31:0] MASK_PIN_A  = 32'hFFFF_FFFE;
  localparam logic [31:0] MASK_PIN_B  = 32'hE80F_E000;
  localparam logic [31:0] MASK_DEVICE = 32'hFFFF_CF78;

  // Field positions in the first pin register.
  localparam int VAR_ADDR_W    = 12;
  localparam int MON_A_LSB     = 19;
  localparam int MON_B_LSB     = 7;
  localparam int BRAKE_LSB     = 5;
  localparam int DIR_LSB       = 3;
  localparam int SPEED_LSB     = 1;

  // Field positions in the second pin register.
  localparam int SHARED_LSB    = 29;
  localparam int PAIR_BIT      = 27;
  localparam int SLEEP_LSB     = 18;
  localparam int WD_EN_BIT     = 17;
  localparam int WD_SRC_BIT    = 16;
  localparam int WD_ACT_BIT    = 15;

  // Brake source encodings.
  localparam logic [1:0] BRAKE_FROM_PIN = 2'h0;
  localparam logic [1:0] BRAKE_FORCE_ON = 2'h1;
  localparam logic [1:0] BRAKE_FORCE_OFF = 2'h2;

  // Direction source encodings; forced clockwise reads as direction level 0.
  localparam logic [1:0] DIR_FROM_PIN   = 2'h0;
  localparam logic [1:0] DIR_FORCE_CW   = 2'h1;
  localparam logic       DIR_CW_LEVEL   = 1'b0;

  // Sleep detection times in microseconds, and their cycle counts.
  localparam int SLEEP_T0_US = 50;
  localparam int SLEEP_T1_US = 200;
  localparam int SLEEP_T2_US = 20000;
  localparam int SLEEP_T3_US = 200000;
  localparam int SLEEP_C0 = SLEEP_T0_US * CLK_MHZ;
  localparam int SLEEP_C1 = SLEEP_T1_US * CLK_MHZ;
  localparam int SLEEP_C2 = SLEEP_T2_US * CLK_MHZ;
  localparam int SLEEP_C3 = SLEEP_T3_US * CLK_MHZ;
  localparam int SLEEP_CNT_W = 23;

  // Decoded configuration handed to the rest of the motor controller.
  typedef struct packed {
    logic [11:0] monitor_a_var_addr;      // Variable shown on the first monitor output.
    logic [11:0] monitor_b_var_addr;      // Variable shown on the second monitor output.
    logic [1:0]  speed_command_source;    // 0 analog, 1 PWM, 2 I2C, 3 frequency.
    logic [1:0]  shared_pin_route;        // 0 monitor_out_b, 1..3 phase sense outputs.
    logic        pin_pair_route;          // 1 puts both monitor outputs on the pin pair.
    logic        watchdog_enable;         // External watchdog on.
    logic        watchdog_service_source; // 0 I2C, 1 GPIO pin.
    logic        watchdog_fault_action;   // 0 report only, 1 latch and float outputs.
  } hpcr_cfg_t;

endpackage : hpcr_pkg

// >>> logic/hpcr_bank.sv
// Hardware pin configuration register bank with its decoded controls.
// Assumes one 25 MHz clock, a same-clock register port from the serial front end or
// nonvolatile loader, and raw pins (brake, direction, sleep, watchdog GPIO) from outside.
`timescale 1ns/1ps
module hpcr_bank #(
  parameter int SLEEP_CYC_2 = hpcr_pkg::SLEEP_C2, // Shorten for simulation.
  parameter int SLEEP_CYC_3 = hpcr_pkg::SLEEP_C3  // Shorten for simulation.
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  output logic      [31:0]       rdata_q,
  output logic                   rvalid_q,
  input  wire logic              brake_pin,
  input  wire logic              dir_pin,
  input  wire logic              sleep_pin,
  input  wire logic              wd_gpio_pin,
  input  wire logic              wd_i2c_kick,
  input  wire logic              wd_expired,
  input  wire logic              wd_fault_clear,
  output hpcr_pkg::hpcr_cfg_t    cfg_q,
  output logic                   brake_active_q,
  output logic                   dir_level_q,
  output logic                   sleep_req_q,
  output logic                   wd_kick_q,
  output logic                   wd_fault_report_q,
  output logic                   wd_fault_latched_q,
  output logic                   power_hiz_q
);

  // The three stored registers.
  logic [31:0] pin_a_q;  // pin_function_select_a.
  logic [31:0] pin_b_q;  // pin_function_select_b.
  logic [31:0] dev_q;    // device_setup_word; its fields are decoded elsewhere.

  // Two-stage synchronisers for the raw pins; only stage two is read by logic.
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic       gpio_prev_q; // Previous synchronised GPIO level for edge detection.

  // Sleep-detect counter.
  logic [hpcr_pkg::SLEEP_CNT_W-1:0] sleep_cnt_q;
  logic [hpcr_pkg::SLEEP_CNT_W-1:0] sleep_lim;

  // Field views.
  logic [1:0] brake_src;
  logic [1:0] dir_src;
  logic [1:0] sleep_sel;
  logic       wd_en;
  logic       wd_src;
  logic       wd_act;

  assign brake_src = pin_a_q[hpcr_pkg::BRAKE_LSB +: 2];
  assign dir_src   = pin_a_q[hpcr_pkg::DIR_LSB +: 2];
  assign sleep_sel = pin_b_q[hpcr_pkg::SLEEP_LSB +: 2];
  assign wd_en     = pin_b_q[hpcr_pkg::WD_EN_BIT];
  assign wd_src    = pin_b_q[hpcr_pkg::WD_SRC_BIT];
  assign wd_act    = pin_b_q[hpcr_pkg::WD_ACT_BIT];

  // Maps the sleep selector to a cycle count; the long settings come from parameters.
  function automatic logic [hpcr_pkg::SLEEP_CNT_W-1:0] sleep_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    sleep_limit = hpcr_pkg::SLEEP_CNT_W'(hpcr_pkg::SLEEP_C0);
      2'h1:    sleep_limit = hpcr_pkg::SLEEP_CNT_W'(hpcr_pkg::SLEEP_C1);
      2'h2:    sleep_limit = hpcr_pkg::SLEEP_CNT_W'(SLEEP_CYC_2);
      default: sleep_limit = hpcr_pkg::SLEEP_CNT_W'(SLEEP_CYC_3);
    endcase
  endfunction : sleep_limit

  assign sleep_lim = sleep_limit(sleep_sel);

  // Register writes. Reserved bits are masked so they stay zero whatever is written.
  // Offsets outside the bank are simply not decoded, so nothing there changes.
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_a_q <= hpcr_pkg::RST_PIN_A;
      pin_b_q <= hpcr_pkg::RST_PIN_B;
      dev_q   <= hpcr_pkg::RST_DEVICE;
    end else if (wr_en) begin
      if (addr == hpcr_pkg::OFS_PIN_A) begin
        pin_a_q <= wdata & hpcr_pkg::MASK_PIN_A;
      end else if (addr == hpcr_pkg::OFS_PIN_B) begin
        pin_b_q <= wdata & hpcr_pkg::MASK_PIN_B;
      end else if (addr == hpcr_pkg::OFS_DEVICE) begin
        dev_q <= wdata & hpcr_pkg::MASK_DEVICE;
      end
    end
  end

  // Register reads; data follows one cycle after the request, unmapped offsets read zero.
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_en;
      if (!rd_en) begin
        rdata_q <= 32'h0000_0000;
      end else if (addr == hpcr_pkg::OFS_PIN_A) begin
        rdata_q <= pin_a_q;
      end else if (addr == hpcr_pkg::OFS_PIN_B) begin
        rdata_q <= pin_b_q;
      end else if (addr == hpcr_pkg::OFS_DEVICE) begin
        rdata_q <= dev_q;
      end else begin
        rdata_q <= 32'h0000_0000; // Reserved offsets hold nothing readable.
      end
    end
  end

  // Pin synchronisers: brake, direction, sleep, watchdog GPIO.
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1_q    <= 4'h0;
      pin_s2_q    <= 4'h0;
      gpio_prev_q <= 1'b0;
    end else begin
      pin_s1_q    <= {wd_gpio_pin, sleep_pin, dir_pin, brake_pin};
      pin_s2_q    <= pin_s1_q;
      gpio_prev_q <= pin_s2_q[3];
    end
  end

  // Decoded configuration, registered so every output leaves from a flip-flop.
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_q <= '0;
    end else begin
      cfg_q.monitor_a_var_addr      <= pin_a_q[hpcr_pkg::MON_A_LSB +: hpcr_pkg::VAR_ADDR_W];
      cfg_q.monitor_b_var_addr      <= pin_a_q[hpcr_pkg::MON_B_LSB +: hpcr_pkg::VAR_ADDR_W];
      cfg_q.speed_command_source    <= pin_a_q[hpcr_pkg::SPEED_LSB +: 2];
      cfg_q.shared_pin_route        <= pin_b_q[hpcr_pkg::SHARED_LSB +: 2];
      cfg_q.pin_pair_route          <= pin_b_q[hpcr_pkg::PAIR_BIT];
      cfg_q.watchdog_enable         <= wd_en;
      cfg_q.watchdog_service_source <= wd_src;
      cfg_q.watchdog_fault_action   <= wd_act;
    end
  end

  // Brake and direction selection. Undefined codes fall back to the pin, the safest reading.
  always_ff @(posedge clk) begin
    if (srst) begin
      brake_active_q <= 1'b0;
      dir_level_q    <= hpcr_pkg::DIR_CW_LEVEL;
    end else begin
      if (brake_src == hpcr_pkg::BRAKE_FORCE_ON) begin
        brake_active_q <= 1'b1;
      end else if (brake_src == hpcr_pkg::BRAKE_FORCE_OFF) begin
        brake_active_q <= 1'b0;
      end else begin
        brake_active_q <= pin_s2_q[0];
      end
      if (dir_src == hpcr_pkg::DIR_FORCE_CW) begin
        dir_level_q <= hpcr_pkg::DIR_CW_LEVEL;
      end else begin
        dir_level_q <= pin_s2_q[1];
      end
    end
  end

  // Sleep detection: the input must stay low for the full selected count.
  // A single high sample restarts the count, which filters glitches at the cost of latency.
  always_ff @(posedge clk) begin
    if (srst) begin
      sleep_cnt_q <= '0;
      sleep_req_q <= 1'b0;
    end else if (pin_s2_q[2]) begin
      sleep_cnt_q <= '0;
      sleep_req_q <= 1'b0;
    end else if (sleep_cnt_q >= sleep_lim - 1'b1) begin
      sleep_req_q <= 1'b1;
    end else begin
      sleep_cnt_q <= sleep_cnt_q + 1'b1;
    end
  end

  // Watchdog service routing and timeout handling. A timeout in the same cycle as a
  // clear keeps the latch set, so a fresh fault is never lost.
  always_ff @(posedge clk) begin
    if (srst) begin
      wd_kick_q          <= 1'b0;
      wd_fault_report_q  <= 1'b0;
      wd_fault_latched_q <= 1'b0;
      power_hiz_q        <= 1'b0;
    end else begin
      wd_kick_q         <= wd_en & (wd_src ? (pin_s2_q[3] & ~gpio_prev_q) : wd_i2c_kick);
      wd_fault_report_q <= wd_en & wd_expired;
      if (wd_en && wd_expired && wd_act) begin
        wd_fault_latched_q <= 1'b1;
        power_hiz_q        <= 1'b1;
      end else if (wd_fault_clear) begin
        wd_fault_latched_q <= 1'b0;
        power_hiz_q        <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_wr_a;
    wr_en && addr == hpcr_pkg::OFS_PIN_A |=> pin_a_q == ($past(wdata) & hpcr_pkg::MASK_PIN_A);
  endproperty
  a_wr_a: assert property (p_wr_a) else $error("first pin register write lost");

  property p_wr_b;
    wr_en && addr == hpcr_pkg::OFS_PIN_B |=> pin_b_q == ($past(wdata) & hpcr_pkg::MASK_PIN_B);
  endproperty
  a_wr_b: assert property (p_wr_b) else $error("second pin register write lost");

  property p_rst;
    disable iff (1'b0) srst |=> pin_a_q == hpcr_pkg::RST_PIN_A && pin_b_q == hpcr_pkg::RST_PIN_B;
  endproperty
  a_rst: assert property (p_rst) else $error("pin registers not cleared by reset");

  property p_brake_on;
    brake_src == hpcr_pkg::BRAKE_FORCE_ON |=> brake_active_q;
  endproperty
  a_brake_on: assert property (p_brake_on) else $error("forced brake not active");

  property p_brake_off;
    brake_src == hpcr_pkg::BRAKE_FORCE_OFF |=> !brake_active_q;
  endproperty
  a_brake_off: assert property (p_brake_off) else $error("disabled brake still active");

  property p_dir_cw;
    dir_src == hpcr_pkg::DIR_FORCE_CW |=> dir_level_q == hpcr_pkg::DIR_CW_LEVEL;
  endproperty
  a_dir_cw: assert property (p_dir_cw) else $error("forced direction not clockwise");

  property p_speed;
    ##1 cfg_q.speed_command_source == $past(pin_a_q[hpcr_pkg::SPEED_LSB +: 2]);
  endproperty
  a_speed: assert property (p_speed) else $error("speed source does not follow register");

  property p_route;
    ##1 cfg_q.shared_pin_route == $past(pin_b_q[hpcr_pkg::SHARED_LSB +: 2]);
  endproperty
  a_route: assert property (p_route) else $error("shared pin route does not follow register");

  property p_report;
    wd_en && wd_expired |=> wd_fault_report_q ##1 !wd_fault_report_q || $past(wd_expired);
  endproperty
  a_report: assert property (p_report) else $error("watchdog fault not reported");

  property p_hiz;
    wd_en && wd_expired && wd_act |=> power_hiz_q && wd_fault_latched_q;
  endproperty
  a_hiz: assert property (p_hiz) else $error("watchdog fault did not float outputs");

  property p_kick_off;
    !wd_en |=> !wd_kick_q;
  endproperty
  a_kick_off: assert property (p_kick_off) else $error("service passed while watchdog disabled");

  property p_sleep_high;
    pin_s2_q[2] |=> !sleep_req_q && sleep_cnt_q == '0;
  endproperty
  a_sleep_high: assert property (p_sleep_high) else $error("sleep request with input high");

endmodule : hpcr_bank

// >>> tb/hpcr_host_model.sv
// Host model that writes and reads the configuration bank on its strobe port.
// Assumes the bank's clock; requests launch just after a rising edge.
`timescale 1ns/1ps
module hpcr_host_model (
  input  wire logic        clk,
  output logic             wr_en,
  output logic             rd_en,
  output logic [7:0]       addr,
  output logic [31:0]      wdata,
  input  wire logic [31:0] rdata_q,
  input  wire logic        rvalid_q
);
  int gap = 0; // Idle cycles after each request, so the host can act slowly.

  // The port is idle at time zero.
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 8'h00;
    wdata = 32'h0000_0000;
  end

  // One write; callers only ever write the mapped offsets, never the reserved ones.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    addr  <= ~a; // Released lines show junk, not the old value.
    wdata <= ~d;
    repeat (gap) @(posedge clk);
  endtask : wr

  // One read; the answer stands for the single cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    addr  <= ~a;
    #1;
    d = rdata_q;
    v = rvalid_q;
    repeat (gap) @(posedge clk);
  endtask : rd
endmodule : hpcr_host_model

// >>> tb/hardware_pin_config_regs_tb.sv
// Self-checking bench for the pin configuration bank.
// Assumes the bank and the host model; sleep counts are shortened by parameter.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module hardware_pin_config_regs_tb;
  localparam int SLP2 = 40; // Shortened 20 ms count.
  localparam int SLP3 = 80; // Shortened 200 ms count.
  logic                clk = 1'b0, srst = 1'b1;
  logic                wr_en, rd_en, rvalid_q, vv;
  logic [7:0]          addr;
  logic [31:0]         wdata, rdata_q, rv;
  logic                brake_pin = 1'b0, dir_pin = 1'b0, sleep_pin = 1'b1, wd_gpio_pin = 1'b0;
  logic                wd_i2c_kick = 1'b0, wd_expired = 1'b0, wd_fault_clear = 1'b0;
  hpcr_pkg::hpcr_cfg_t cfg_q;
  logic                brake_active_q, dir_level_q, sleep_req_q, wd_kick_q;
  logic                wd_fault_report_q, wd_fault_latched_q, power_hiz_q;
  int                  miscompares = 0, total_checks = 0, n;

  // Free-running 25 MHz clock.
  always #20 clk = ~clk;

  hpcr_bank #(.SLEEP_CYC_2(SLP2), .SLEEP_CYC_3(SLP3)) i_hpcr_bank (.clk(clk), .srst(srst),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
    .brake_pin(brake_pin), .dir_pin(dir_pin), .sleep_pin(sleep_pin), .wd_gpio_pin(wd_gpio_pin),
    .wd_i2c_kick(wd_i2c_kick), .wd_expired(wd_expired), .wd_fault_clear(wd_fault_clear),
    .cfg_q(cfg_q), .brake_active_q(brake_active_q), .dir_level_q(dir_level_q),
    .sleep_req_q(sleep_req_q), .wd_kick_q(wd_kick_q), .wd_fault_report_q(wd_fault_report_q),
    .wd_fault_latched_q(wd_fault_latched_q), .power_hiz_q(power_hiz_q));
  hpcr_host_model i_hpcr_host_model (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata_q(rdata_q), .rvalid_q(rvalid_q));

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  // Reads one register and checks the data and its valid flag.
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    i_hpcr_host_model.rd(a, rv, vv);
    `CHK(nm, e, rv)
    `CHK("rvalid", 1'b1, vv)
  endtask : rchk

  // Lets k edges pass, then steps off the edge so outputs have settled.
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : settle

  // One-cycle pulse on a watchdog input: 0 timeout, 1 service, 2 clear.
  task automatic pulse(input int w);
    @(posedge clk);
    case (w)
      0: wd_expired <= 1'b1;
      1: wd_i2c_kick <= 1'b1;
      default: wd_fault_clear <= 1'b1;
    endcase
    @(posedge clk);
    {wd_expired, wd_i2c_kick, wd_fault_clear} <= 3'h0;
    #1;
  endtask : pulse

  // Bounded wait for sleep request (0) or kick (1); a hang ends the run.
  task automatic wait_for(input int s, input int lim, output int c);
    c = 0;
    while (((s == 0) ? sleep_req_q : wd_kick_q) !== 1'b1) begin
      settle(1);
      c++;
      if (c > lim) begin
        miscompares++;
        conclude();
      end
    end
  endtask : wait_for

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rchk("pin_a", 8'hA4, 32'h0000_0000);
    rchk("pin_b", 8'hA6, 32'h0000_0000);
    `CHK("cfg", 32'h0000_0000, cfg_q)
    $display("test reset done");
    // All-ones writes show which bits hold; reserved ones must read zero.
    i_hpcr_host_model.wr(8'hA4, 32'hFFFF_FFFF);
    i_hpcr_host_model.wr(8'hA6, 32'hFFFF_FFFF);
    i_hpcr_host_model.gap = 2;
    i_hpcr_host_model.wr(8'hA8, 32'hFFFF_FFFF);
    rchk("pin_a", 8'hA4, 32'hFFFF_FFFE);
    rchk("pin_b", 8'hA6, 32'hE80F_E000);
    rchk("device", 8'hA8, hpcr_pkg::MASK_DEVICE);
    rchk("hole", 8'hA5, 32'h0000_0000);
    rchk("hole", 8'hAA, 32'h0000_0000);
    i_hpcr_host_model.gap = 0;
    i_hpcr_host_model.wr(8'hA4, {1'b0, 12'hABC, 12'h123, 7'h0});
    settle(3);
    `CHK("mon_a", 12'hABC, cfg_q.monitor_a_var_addr)
    `CHK("mon_b", 12'h123, cfg_q.monitor_b_var_addr)
    $display("test map done");
    for (int s = 0; s < 4; s++) begin
      i_hpcr_host_model.wr(8'hA4, {29'h0, s[1:0], 1'b0});
      settle(3);
      `CHK("speed", s[1:0], cfg_q.speed_command_source)
      i_hpcr_host_model.wr(8'hA6, {1'b0, s[1:0], 1'b0, s[0], 27'h0});
      settle(3);
      `CHK("shared", s[1:0], cfg_q.shared_pin_route)
      `CHK("pair", s[0], cfg_q.pin_pair_route)
    end
    $display("test select done");
    // Each brake code against both pin levels; code 1 also forces clockwise.
    for (int br = 0; br < 3; br++) begin
      for (int p = 0; p < 2; p++) begin
        i_hpcr_host_model.wr(8'hA4, {25'h0, br[1:0], 1'b0, br == 1, 3'h0});
        brake_pin <= p[0];
        dir_pin   <= p[0];
        settle(6);
        `CHK("brake", (br == 0) ? p[0] : (br == 1), brake_active_q)
        `CHK("dir", (br == 1) ? 1'b0 : p[0], dir_level_q)
      end
    end
    $display("test pins done");
    for (int c = 2; c < 4; c++) begin
      i_hpcr_host_model.wr(8'hA6, {12'h0, c[1:0], 18'h0});
      sleep_pin <= 1'b0;
      wait_for(0, 200, n);
      `CHK("sleep_time", 1'b1, (n >= SLP2 * (c - 1)) && (n <= SLP2 * (c - 1) + 8))
      @(posedge clk);
      sleep_pin <= 1'b1;
      settle(6);
      `CHK("sleep_off", 1'b0, sleep_req_q)
    end
    $display("test sleep done");
    // Watchdog: disabled, report only, latched with outputs floated, service routes.
    i_hpcr_host_model.wr(8'hA6, 32'h0000_0000);
    pulse(0);
    `CHK("report_off", 1'b0, wd_fault_report_q)
    pulse(1);
    `CHK("kick_off", 1'b0, wd_kick_q)
    i_hpcr_host_model.wr(8'hA6, 32'h0002_0000);
    pulse(1);
    `CHK("kick_i2c", 1'b1, wd_kick_q)
    pulse(0);
    `CHK("report", 1'b1, wd_fault_report_q)
    `CHK("latch_off", 1'b0, wd_fault_latched_q)
    i_hpcr_host_model.wr(8'hA6, 32'h0002_8000);
    pulse(0);
    settle(3);
    `CHK("latch", 1'b1, wd_fault_latched_q)
    `CHK("hiz", 1'b1, power_hiz_q)
    `CHK("wd_cfg", 3'h5, {cfg_q.watchdog_enable, cfg_q.watchdog_service_source, cfg_q.watchdog_fault_action})
    // A timeout in the same cycle as a clear must leave the fault latched.
    @(posedge clk);
    {wd_expired, wd_fault_clear} <= 2'h3;
    @(posedge clk);
    {wd_expired, wd_fault_clear} <= 2'h0;
    #1;
    `CHK("latch_wins", 1'b1, wd_fault_latched_q)
    pulse(2);
    `CHK("hiz_clr", 1'b0, power_hiz_q)
    `CHK("latch_clr", 1'b0, wd_fault_latched_q)
    i_hpcr_host_model.wr(8'hA6, 32'h0003_0000);
    pulse(1);
    `CHK("kick_gpio_only", 1'b0, wd_kick_q)
    `CHK("wd_cfg", 3'h6, {cfg_q.watchdog_enable, cfg_q.watchdog_service_source, cfg_q.watchdog_fault_action})
    @(posedge clk);
    wd_gpio_pin <= 1'b1;
    wait_for(1, 8, n);
    `CHK("kick_gpio", 1'b1, wd_kick_q)
    $display("test watchdog done");
    // A second reset must clear registers that now hold nonzero values.
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rchk("pin_a_rst", 8'hA4, 32'h0000_0000);
    rchk("pin_b_rst", 8'hA6, 32'h0000_0000);
    $display("test rearm done");
    conclude();
  end
endmodule : hardware_pin_config_regs_tb
